/* verilog/bmt_bridge.sv */
// Bus-master routing, monitoring and page translation top
`timescale 1ns/10ps
`default_nettype none
module bmt_bridge (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic CSR_WR,
  input wire logic CSR_RD,
  input wire logic [3:0] CSR_CHAN,
  input wire logic [31:0] CSR_WDATA,
  output logic [31:0] CSR_RDATA,
  input wire logic CMD_ENABLE,
  input wire logic CMD_DISABLE,
  input wire logic [3:0] CMD_CHAN,
  input wire logic IO_OP_VALID,
  input wire logic [7:0] IO_OP_LEN,
  output logic IO_STR_GO,
  output logic [7:0] IO_STR_LEN,
  input wire logic BM_START,
  input wire logic [3:0] BM_CHAN,
  input wire logic [31:0] BM_ADDR,
  input wire logic [3:0] BM_PAR,
  input wire logic BM_MIO,
  input wire logic BM_CARD_FB,
  input wire logic BUS_MAP_EN,
  input wire logic [11:0] BUS_MAP_BLOCK,
  input wire logic [31:0] XLT_BASE,
  input wire logic [19:0] XLT_ENTRIES,
  output logic MEM_RD_REQ,
  output logic [31:0] MEM_RD_ADDR,
  input wire logic MEM_RD_ACK,
  input wire logic MEM_RD_ERR,
  input wire logic [31:0] MEM_RD_DATA,
  output logic SYS_VALID,
  output logic [31:0] SYS_ADDR,
  output logic BM_MONITOR,
  output logic ERR_LOGGED,
  output logic [3:0] ERR_CODE
);
  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  localparam int PW = 43;
  logic [PW-1:0] pin_s1;
  logic [PW-1:0] pin_s2;
  logic start_d;
  logic s_start;
  logic [3:0] s_chan;
  logic [31:0] s_addr;
  logic [3:0] s_par;
  logic s_mio;
  logic s_fb;
  logic start_edge;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      start_d <= 1'b0;
    end else begin
      pin_s1 <= {BM_START, BM_CHAN, BM_ADDR, BM_PAR, BM_MIO, BM_CARD_FB};
      pin_s2 <= pin_s1;
      start_d <= s_start;
    end
  end

  assign {s_start, s_chan, s_addr, s_par, s_mio, s_fb} = pin_s2;
  assign start_edge = s_start & ~start_d;

  // ---------------------------------------------------------------
  // Parity and register bank
  // ---------------------------------------------------------------
  logic s_par_err;
  logic log_valid;
  logic [3:0] log_code;
  logic [5:0] sel_csr;
  logic [5:0] rd_csr;
  bmt_pkg::bmt_state_e state;
  bmt_pkg::bmt_state_e next_state;
  logic [3:0] cur_chan;
  logic [31:0] cur_addr;
  logic cur_mio;
  logic cur_fb;
  logic cur_par_err;
  logic [5:0] cur_csr;

  bmt_addr_parity u_par (
    .addr(s_addr),
    .par(s_par),
    .io_space(~s_mio),
    .err(s_par_err)
  );

  bmt_csr_bank #(
    .NUM_CHAN(bmt_pkg::NUM_CHAN)
  ) u_bank (
    .clk(CORE_CLK),
    .rst(RESET),
    .sw_wr(CSR_WR),
    .sw_chan(CSR_CHAN),
    .sw_wdata(CSR_WDATA[5:0]),
    .cmd_en(CMD_ENABLE),
    .cmd_dis(CMD_DISABLE),
    .cmd_chan(CMD_CHAN),
    .log_valid(log_valid),
    .log_chan(cur_chan),
    .log_code(log_code),
    .sel_chan(cur_chan),
    .sel_csr(sel_csr),
    .rd_chan(CSR_CHAN),
    .rd_csr(rd_csr)
  );

  // ---------------------------------------------------------------
  // Routing decision
  // ---------------------------------------------------------------
  logic prevent;
  logic map_hit;
  logic bus2bus;
  logic [19:0] page;
  logic [31:0] xlt_addr;
  logic [19:0] xlt_page;
  logic xlt_mapped;

  always_comb begin
    prevent = cur_csr[bmt_pkg::CSR_PREVENT_BIT];
    map_hit = (cur_addr[31:bmt_pkg::BUS_BLOCK_LSB] == BUS_MAP_BLOCK);
    // I/O space never reaches system memory
    bus2bus = ~cur_mio | (BUS_MAP_EN & map_hit);
    page = cur_addr[31:bmt_pkg::PAGE_BITS];
    xlt_addr = XLT_BASE + {10'h000, page, 2'h0};
    xlt_page = MEM_RD_DATA[31:bmt_pkg::XLT_PAGE_LSB];
    xlt_mapped = (MEM_RD_DATA[1:0] == bmt_pkg::XLT_MAPPED);
  end

  // ---------------------------------------------------------------
  // Transfer controller
  // ---------------------------------------------------------------
  logic next_mem_req;
  logic [31:0] next_mem_addr;
  logic next_sys_valid;
  logic [31:0] next_sys_addr;
  logic next_monitor;
  logic next_err_logged;
  logic [3:0] next_err_code;
  logic [3:0] next_chan;
  logic [31:0] next_addr;
  logic next_mio;
  logic next_fb;
  logic next_par_err;
  logic [5:0] next_csr;
  logic [31:0] next_rdata;
  logic next_io_go;
  logic [7:0] next_io_len;

  always_comb begin
    next_state = state;
    next_chan = cur_chan;
    next_addr = cur_addr;
    next_mio = cur_mio;
    next_fb = cur_fb;
    next_par_err = cur_par_err;
    next_csr = cur_csr;
    next_mem_req = MEM_RD_REQ;
    next_mem_addr = MEM_RD_ADDR;
    next_sys_valid = 1'b0;
    next_sys_addr = SYS_ADDR;
    next_monitor = 1'b0;
    log_valid = 1'b0;
    log_code = bmt_pkg::STAT_DISABLED;
    case (state)
      bmt_pkg::ST_IDLE: begin
        if (start_edge) begin
          next_chan = s_chan;
          next_addr = s_addr;
          next_mio = s_mio;
          next_fb = s_fb;
          next_par_err = s_par_err;
          next_state = bmt_pkg::ST_SELECT;
        end
      end
      bmt_pkg::ST_SELECT: begin
        next_csr = sel_csr;
        if (cur_chan == bmt_pkg::NO_CSR_CHAN || sel_csr[3:0] != bmt_pkg::STAT_ENABLED) begin
          next_state = bmt_pkg::ST_IDLE;
        end else begin
          next_state = bmt_pkg::ST_ROUTE;
        end
      end
      bmt_pkg::ST_ROUTE: begin
        next_state = bmt_pkg::ST_IDLE;
        if (cur_par_err) begin
          if (prevent) begin
            next_monitor = 1'b1;
          end else begin
            log_valid = 1'b1;
            log_code = bmt_pkg::ERR_ADDR_PARITY;
          end
        end else if (bus2bus) begin
          next_monitor = 1'b1;
          if (!prevent && !cur_fb) begin
            log_valid = 1'b1;
            log_code = bmt_pkg::ERR_CARD_SEL;
          end
        end else if (page >= XLT_ENTRIES) begin
          log_valid = 1'b1;
          log_code = bmt_pkg::ERR_XLT_RANGE;
        end else begin
          next_mem_req = 1'b1;
          next_mem_addr = xlt_addr;
          next_state = bmt_pkg::ST_XLT_WAIT;
        end
      end
      bmt_pkg::ST_XLT_WAIT: begin
        if (MEM_RD_ACK) begin
          next_mem_req = 1'b0;
          next_state = bmt_pkg::ST_IDLE;
          if (MEM_RD_ERR) begin
            log_valid = 1'b1;
            log_code = bmt_pkg::ERR_XLT_ACCESS;
          end else if (xlt_mapped) begin
            next_sys_valid = 1'b1;
            next_sys_addr = {xlt_page, cur_addr[bmt_pkg::PAGE_BITS-1:0]};
          end else begin
            log_valid = 1'b1;
            log_code = bmt_pkg::ERR_PAGE_UNMAPPED;
          end
        end
      end
      default: begin
        next_state = bmt_pkg::ST_IDLE;
      end
    endcase
    next_err_logged = log_valid;
    next_err_code = log_valid ? log_code : ERR_CODE;
    next_rdata = CSR_RD ? {26'h0, rd_csr} : CSR_RDATA;
    // Multiple and string requests arrive as one byte-length request
    next_io_go = IO_OP_VALID;
    next_io_len = IO_OP_VALID ? IO_OP_LEN : IO_STR_LEN;
  end

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state <= bmt_pkg::ST_IDLE;
      cur_chan <= 4'h0;
      cur_addr <= 32'h00000000;
      cur_mio <= 1'b0;
      cur_fb <= 1'b0;
      cur_par_err <= 1'b0;
      cur_csr <= bmt_pkg::CSR_RESET;
      MEM_RD_REQ <= 1'b0;
      MEM_RD_ADDR <= 32'h00000000;
      SYS_VALID <= 1'b0;
      SYS_ADDR <= 32'h00000000;
      BM_MONITOR <= 1'b0;
      ERR_LOGGED <= 1'b0;
      ERR_CODE <= 4'h0;
      CSR_RDATA <= 32'h00000000;
      IO_STR_GO <= 1'b0;
      IO_STR_LEN <= 8'h00;
    end else begin
      state <= next_state;
      cur_chan <= next_chan;
      cur_addr <= next_addr;
      cur_mio <= next_mio;
      cur_fb <= next_fb;
      cur_par_err <= next_par_err;
      cur_csr <= next_csr;
      MEM_RD_REQ <= next_mem_req;
      MEM_RD_ADDR <= next_mem_addr;
      SYS_VALID <= next_sys_valid;
      SYS_ADDR <= next_sys_addr;
      BM_MONITOR <= next_monitor;
      ERR_LOGGED <= next_err_logged;
      ERR_CODE <= next_err_code;
      CSR_RDATA <= next_rdata;
      IO_STR_GO <= next_io_go;
      IO_STR_LEN <= next_io_len;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RESET);

  no_csr_chan_a: assert property (
    state == bmt_pkg::ST_SELECT && cur_chan == bmt_pkg::NO_CSR_CHAN |=> state == bmt_pkg::ST_IDLE)
    else $error("channel 0xF started a transfer");
  winner_csr_a: assert property (
    state == bmt_pkg::ST_SELECT && sel_csr[3:0] != bmt_pkg::STAT_ENABLED
    |=> state == bmt_pkg::ST_IDLE ##1 !BM_MONITOR && !MEM_RD_REQ)
    else $error("disabled channel was served");
  monitor_only_a: assert property (
    BM_MONITOR |-> !MEM_RD_REQ && !SYS_VALID)
    else $error("device took part in a bus-to-bus transfer");
  io_disjoint_a: assert property (
    state == bmt_pkg::ST_ROUTE && !cur_mio |=> !MEM_RD_REQ && state == bmt_pkg::ST_IDLE)
    else $error("I/O space access went to system memory");
  card_fb_log_a: assert property (
    state == bmt_pkg::ST_ROUTE && !cur_par_err && bus2bus && !prevent && !cur_fb
    |=> ERR_LOGGED && ERR_CODE == bmt_pkg::ERR_CARD_SEL)
    else $error("card-selected feedback error not logged");
  prevent_quiet_a: assert property (
    state == bmt_pkg::ST_ROUTE && (bus2bus || cur_par_err) && prevent
    |=> !ERR_LOGGED && BM_MONITOR)
    else $error("error logged while disable is prevented");
  entry_fetch_a: assert property (
    $rose(MEM_RD_REQ) |-> MEM_RD_ADDR == XLT_BASE + {10'h000, cur_addr[31:12], 2'h0}
    ##1 MEM_RD_REQ)
    else $error("wrong translation entry address");
  sys_addr_a: assert property (
    SYS_VALID |-> SYS_ADDR[11:0] == cur_addr[11:0] && $past(MEM_RD_ACK) && !$past(MEM_RD_ERR))
    else $error("system address offset wrong");
  table_err_a: assert property (
    state == bmt_pkg::ST_XLT_WAIT && MEM_RD_ACK && MEM_RD_ERR
    |=> ERR_LOGGED && ERR_CODE == bmt_pkg::ERR_XLT_ACCESS && !SYS_VALID)
    else $error("table access error not reported");
  sysmem_err_a: assert property (
    state == bmt_pkg::ST_XLT_WAIT && MEM_RD_ACK && !(!MEM_RD_ERR && xlt_mapped)
    |=> ERR_LOGGED ##1 u_bank.csr[cur_chan][3:0] != bmt_pkg::STAT_ENABLED)
    else $error("system memory error did not disable channel");

  translate_c: cover property (SYS_VALID);
  monitor_c: cover property (BM_MONITOR && !ERR_LOGGED);
  card_err_c: cover property (ERR_LOGGED && ERR_CODE == bmt_pkg::ERR_CARD_SEL);
  unmapped_c: cover property (ERR_LOGGED && ERR_CODE == bmt_pkg::ERR_PAGE_UNMAPPED);
endmodule
`default_nettype wire

/* common/bmt_pkg.sv */
// Constants and types for the bus-master channel translation block
// Function
// - I/O load/store multiple is handled exactly like a string op of equal length
// - Bus mapping decides system memory versus bus-to-bus for each master memory-space access
// - Enabled channel targeting the expansion bus: only monitor, check address parity
// - Bus-to-bus monitoring also checks card-selected feedback when prevent bit is 0
// - I/O space master accesses check parity on address bits 0 to 15 only
// - System memory accesses are translated through the in-memory entry table
// - For masters, I/O space is disjoint from bus memory, chosen by M/IO
// - Channels 0 to 14 own a status register; channel 0xF has none
// - After arbitration the winner's status register governs the transfer
// - Translation works on 4 KB pages, one entry per page
// - Status bits 0-3: 0x0 disabled, 0x1 enabled, 0x2-0xF error codes
// - Enable and disable commands update status bits 0-3
// - Software clears bit 4 for bus-master use; hardware never changes it
// - Prevent bit 1 suppresses logging and disabling only for bus-to-bus monitoring
// - Errors during system memory transfers always log and disable the channel
// - Uncertain target with prevent bit 1: treat as bus-to-bus, no logging
// - System address is real page number plus low 12 bus address bits
// - Entry k maps bus page k, entry zero from address zero
// - Any error reading translation entries reports a table access error
// - Entry mapping information is used only when its page is mapped
package bmt_pkg;
  // ---------------------------------------------------------------
  // Channel status and control layout
  // ---------------------------------------------------------------
  localparam int CSR_W = 6;
  localparam int CSR_SLAVE_BIT = 4;
  localparam int CSR_PREVENT_BIT = 5;
  localparam logic [5:0] CSR_RESET = 6'h00;
  localparam int NUM_CHAN = 15;
  localparam logic [3:0] NO_CSR_CHAN = 4'hF;
  // ---------------------------------------------------------------
  // Status codes
  // ---------------------------------------------------------------
  localparam logic [3:0] STAT_DISABLED = 4'h0;
  localparam logic [3:0] STAT_ENABLED = 4'h1;
  localparam logic [3:0] ERR_ADDR_PARITY = 4'h2;
  localparam logic [3:0] ERR_CARD_SEL = 4'h3;
  localparam logic [3:0] ERR_XLT_ACCESS = 4'h4;
  localparam logic [3:0] ERR_PAGE_UNMAPPED = 4'h5;
  localparam logic [3:0] ERR_XLT_RANGE = 4'h6;
  // ---------------------------------------------------------------
  // Translation entry and addressing
  // ---------------------------------------------------------------
  localparam int PAGE_BITS = 12;
  localparam int XLT_PAGE_LSB = 12;
  localparam logic [1:0] XLT_MAPPED = 2'h3;
  localparam int BUS_BLOCK_LSB = 20;
  // ---------------------------------------------------------------
  // Controller states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_SELECT = 2'h1,
    ST_ROUTE = 2'h3,
    ST_XLT_WAIT = 2'h2
  } bmt_state_e;
endpackage

/* verilog/bmt_addr_parity.sv */
// Odd parity check of a bus-master address, per byte
`timescale 1ns/10ps
`default_nettype none
module bmt_addr_parity (
  input wire logic [31:0] addr,
  input wire logic [3:0] par,
  input wire logic io_space,
  output logic err
);
  logic [3:0] bad;

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bad[i] = ~(^{addr[8*i +: 8], par[i]});
    end
    // I/O space only covers the low 16 address bits
    err = io_space ? (bad[0] | bad[1]) : (|bad);
  end
endmodule
`default_nettype wire

/* verilog/bmt_csr_bank.sv */
// Bank of per-channel status and control registers
`timescale 1ns/10ps
`default_nettype none
module bmt_csr_bank #(
  parameter int NUM_CHAN = bmt_pkg::NUM_CHAN
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sw_wr,
  input wire logic [3:0] sw_chan,
  input wire logic [5:0] sw_wdata,
  input wire logic cmd_en,
  input wire logic cmd_dis,
  input wire logic [3:0] cmd_chan,
  input wire logic log_valid,
  input wire logic [3:0] log_chan,
  input wire logic [3:0] log_code,
  input wire logic [3:0] sel_chan,
  output logic [5:0] sel_csr,
  input wire logic [3:0] rd_chan,
  output logic [5:0] rd_csr
);
  logic [5:0] csr [NUM_CHAN];
  logic [5:0] next_csr [NUM_CHAN];

  // ---------------------------------------------------------------
  // Update: device log beats software write beats command
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      next_csr[i] = csr[i];
      if (cmd_en && cmd_chan == 4'(i)) begin
        next_csr[i][3:0] = bmt_pkg::STAT_ENABLED;
      end else if (cmd_dis && cmd_chan == 4'(i)) begin
        next_csr[i][3:0] = bmt_pkg::STAT_DISABLED;
      end
      if (sw_wr && sw_chan == 4'(i)) begin
        next_csr[i] = sw_wdata;
      end
      // Hardware touches only the status field, never the slave flag
      if (log_valid && log_chan == 4'(i)) begin
        next_csr[i][3:0] = log_code;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        csr[i] <= bmt_pkg::CSR_RESET;
      end
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        csr[i] <= next_csr[i];
      end
    end
  end

  // Channel 0xF has no register and reads zero
  always_comb begin
    sel_csr = (sel_chan < 4'(NUM_CHAN)) ? csr[sel_chan] : 6'h00;
    rd_csr = (rd_chan < 4'(NUM_CHAN)) ? csr[rd_chan] : 6'h00;
  end
endmodule
`default_nettype wire

/* verification/bmt_mem_model.sv */
// System memory model that serves translation entries to the bridge
`timescale 1ns/10ps
`default_nettype none
module bmt_mem_model #(
  parameter logic [31:0] BASE = 32'h0001_0000
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [31:0] addr,
  input wire logic slow,
  output logic ack,
  output logic err,
  output logic [31:0] data
);
  logic busy;
  logic done;
  logic [3:0] cnt;
  logic [19:0] idx;

  // ---------------------------------------------------------------
  // Entry k sits at BASE + 4k; page 3 unmapped, page 5 faults
  // ---------------------------------------------------------------
  assign idx = 20'((addr - BASE) >> 2);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      cnt <= 4'h0;
      ack <= 1'b0;
      err <= 1'b0;
      data <= 32'h5A5A_5A5A;
    end else begin
      ack <= 1'b0;
      err <= 1'b0;
      // Data is meaningless outside the answer cycle, so keep it moving
      data <= ~data;
      if (!req) begin
        busy <= 1'b0;
        done <= 1'b0;
      end else if (!busy) begin
        busy <= 1'b1;
        cnt <= slow ? 4'h6 : 4'h0;
      end else if (!done && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (!done) begin
        ack <= 1'b1;
        done <= 1'b1;
        err <= (idx == 20'h00005);
        data <= {20'h000A0 + idx, 10'h000, (idx == 20'h00003) ? 2'h0 : 2'h3};
      end
    end
  end
endmodule
`default_nettype wire

/* verification/bmt_bridge_tb.sv */
// Self-checking testbench of the bus-master channel translation bridge
`timescale 1ns/10ps
`default_nettype none
module bmt_bridge_tb;
  typedef struct packed {
    logic [3:0] chan;
    logic [5:0] wcsr;
    logic [31:0] addr;
    logic mio;
    logic fb;
    logic bad;
    logic [2:0] ex;
    logic [3:0] code;
    logic [31:0] sa;
  } bmt_row_s;

  localparam logic [31:0] TB_BASE = 32'h0001_0000;
  logic clk, rst, csr_wr, csr_rd, cmd_en, cmd_dis, io_vld, bm_start, bm_mio, bm_fb, map_en;
  logic mem_req, mem_ack, mem_err, sys_vld, bm_mon, err_log, io_go, slow;
  logic [2:0] seen;
  logic [3:0] csr_chan, cmd_chan, bm_chan, bm_par, err_code, st;
  logic [7:0] io_len, str_len;
  logic [11:0] map_blk;
  logic [19:0] xlt_n;
  logic [31:0] csr_wdata, csr_rdata, bm_addr, mem_addr, mem_data, sys_addr;
  int errors;
  int checks_done;

  // ---------------------------------------------------------------
  // Ordinary cases: ex = {system valid, monitor, error logged}
  // ---------------------------------------------------------------
  bmt_row_s rows [16] = '{
    '{4'h1, 6'h01, 32'h00002ABC, 1'b1, 1'b1, 1'b0, 3'h4, 4'h0, 32'h000A2ABC},
    '{4'h2, 6'h01, 32'h00000FFF, 1'b1, 1'b1, 1'b0, 3'h4, 4'h0, 32'h000A0FFF},
    '{4'h3, 6'h21, 32'h0000F000, 1'b1, 1'b1, 1'b0, 3'h4, 4'h0, 32'h000AF000},
    '{4'h4, 6'h01, 32'h00F01234, 1'b1, 1'b1, 1'b0, 3'h2, 4'h0, 32'h00000000},
    '{4'h5, 6'h01, 32'h00F01234, 1'b1, 1'b0, 1'b0, 3'h3, 4'h3, 32'h00000000},
    '{4'h6, 6'h01, 32'h00005000, 1'b0, 1'b1, 1'b0, 3'h2, 4'h0, 32'h00000000},
    '{4'h7, 6'h21, 32'h00F00000, 1'b1, 1'b0, 1'b0, 3'h2, 4'h0, 32'h00000000},
    '{4'h8, 6'h21, 32'h00002000, 1'b1, 1'b1, 1'b1, 3'h2, 4'h0, 32'h00000000},
    '{4'h9, 6'h01, 32'h00002000, 1'b1, 1'b1, 1'b1, 3'h1, 4'h2, 32'h00000000},
    '{4'hA, 6'h01, 32'h00001234, 1'b0, 1'b1, 1'b1, 3'h2, 4'h0, 32'h00000000},
    '{4'hB, 6'h11, 32'h00003000, 1'b1, 1'b1, 1'b0, 3'h1, 4'h5, 32'h00000000},
    '{4'hC, 6'h01, 32'h00005000, 1'b1, 1'b1, 1'b0, 3'h1, 4'h4, 32'h00000000},
    '{4'hD, 6'h01, 32'h00014000, 1'b1, 1'b1, 1'b0, 3'h1, 4'h6, 32'h00000000},
    '{4'hE, 6'h21, 32'h00005010, 1'b1, 1'b1, 1'b0, 3'h1, 4'h4, 32'h00000000},
    '{4'hF, 6'h01, 32'h00002000, 1'b1, 1'b1, 1'b0, 3'h0, 4'h0, 32'h00000000},
    '{4'h0, 6'h00, 32'h00002000, 1'b1, 1'b1, 1'b0, 3'h0, 4'h0, 32'h00000000}
  };

  bmt_bridge u_dut (
    .CORE_CLK(clk), .RESET(rst), .CSR_WR(csr_wr), .CSR_RD(csr_rd), .CSR_CHAN(csr_chan),
    .CSR_WDATA(csr_wdata), .CSR_RDATA(csr_rdata), .CMD_ENABLE(cmd_en), .CMD_DISABLE(cmd_dis),
    .CMD_CHAN(cmd_chan), .IO_OP_VALID(io_vld), .IO_OP_LEN(io_len), .IO_STR_GO(io_go),
    .IO_STR_LEN(str_len), .BM_START(bm_start), .BM_CHAN(bm_chan), .BM_ADDR(bm_addr),
    .BM_PAR(bm_par), .BM_MIO(bm_mio), .BM_CARD_FB(bm_fb), .BUS_MAP_EN(map_en),
    .BUS_MAP_BLOCK(map_blk), .XLT_BASE(TB_BASE), .XLT_ENTRIES(xlt_n), .MEM_RD_REQ(mem_req),
    .MEM_RD_ADDR(mem_addr), .MEM_RD_ACK(mem_ack), .MEM_RD_ERR(mem_err),
    .MEM_RD_DATA(mem_data), .SYS_VALID(sys_vld), .SYS_ADDR(sys_addr), .BM_MONITOR(bm_mon),
    .ERR_LOGGED(err_log), .ERR_CODE(err_code)
  );

  bmt_mem_model #(.BASE(TB_BASE)) u_mem (
    .clk(clk), .rst(rst), .req(mem_req), .addr(mem_addr), .slow(slow),
    .ack(mem_ack), .err(mem_err), .data(mem_data)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] opar(input logic [31:0] a);
    logic [3:0] p;
    for (int i = 0; i < 4; i++) begin
      p[i] = ~^a[8*i +: 8];
    end
    return p;
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic csr_write(input logic [3:0] ch, input logic [31:0] d);
    @(posedge clk);
    csr_wr <= 1'b1;
    csr_chan <= ch;
    csr_wdata <= d;
    @(posedge clk);
    csr_wr <= 1'b0;
  endtask

  task automatic csr_check(input logic [3:0] ch, input logic [31:0] exp);
    @(posedge clk);
    csr_rd <= 1'b1;
    csr_chan <= ch;
    @(posedge clk);
    csr_rd <= 1'b0;
    @(posedge clk);
    #1;
    chk("channel register", exp, csr_rdata);
  endtask

  task automatic command(input logic en, input logic [3:0] ch);
    @(posedge clk);
    cmd_en <= en;
    cmd_dis <= ~en;
    cmd_chan <= ch;
    @(posedge clk);
    cmd_en <= 1'b0;
    cmd_dis <= 1'b0;
  endtask

  task automatic xfer(input bmt_row_s r);
    int left;
    @(posedge clk);
    bm_chan <= r.chan;
    bm_addr <= r.addr;
    bm_mio <= r.mio;
    bm_fb <= r.fb;
    bm_par <= opar(r.addr) ^ {r.bad, 3'h0};
    bm_start <= 1'b1;
    seen = 3'h0;
    left = 40;
    while (left > 0) begin
      @(posedge clk);
      #1;
      seen = seen | {sys_vld, bm_mon, err_log};
      left = (seen != 3'h0 && left > 2) ? 2 : left - 1;
    end
    @(posedge clk);
    bm_start <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    repeat (3000) @(posedge clk);
    errors++;
    close_out;
  end

  initial begin
    errors = 0;
    checks_done = 0;
    {rst, csr_wr, csr_rd, cmd_en, cmd_dis, io_vld, bm_start, bm_mio, bm_fb, slow} = 10'h200;
    {csr_chan, cmd_chan, bm_chan, bm_par, io_len} = 24'h000000;
    {csr_wdata, bm_addr} = 64'h0;
    map_en = 1'b1;
    map_blk = 12'h00F;
    xlt_n = 20'h00010;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("outputs after reset", 32'h0, {27'h0, mem_req, sys_vld, bm_mon, err_log, io_go});
    csr_check(4'h1, 32'h0);
    foreach (rows[i]) begin
      slow <= i[0];
      if (rows[i].chan != 4'hF) csr_write(rows[i].chan, {26'h0, rows[i].wcsr});
      xfer(rows[i]);
      chk("route", {29'h0, rows[i].ex}, {29'h0, seen});
      if (rows[i].ex[2]) chk("system address", rows[i].sa, sys_addr);
      if (rows[i].ex[0]) chk("error code", {28'h0, rows[i].code}, {28'h0, err_code});
      st = rows[i].ex[0] ? rows[i].code : rows[i].wcsr[3:0];
      csr_check(rows[i].chan,
                rows[i].chan == 4'hF ? 32'h0 : {26'h0, rows[i].wcsr[5:4], st});
    end
    command(1'b0, 4'h1);
    csr_check(4'h1, 32'h0);
    command(1'b1, 4'h1);
    csr_check(4'h1, 32'h1);
    csr_write(4'h2, 32'hFFFF_FFE5);
    csr_check(4'h2, 32'h25);
    @(posedge clk);
    io_vld <= 1'b1;
    io_len <= 8'h80;
    @(posedge clk);
    io_len <= 8'h01;
    #1;
    chk("string start", 32'h180, {23'h0, io_go, str_len});
    @(posedge clk);
    io_vld <= 1'b0;
    #1;
    chk("string start", 32'h101, {23'h0, io_go, str_len});
    @(posedge clk);
    #1;
    chk("string start", 32'h001, {23'h0, io_go, str_len});
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    csr_check(4'h2, 32'h0);
    close_out;
  end
endmodule
`default_nettype wire
